// File: hdl/prs_pkg.sv
// Purpose: Shared constants and types for the processor reset sequencer
// Assumes: pclk at 100 MHz, APB register access
// Notes: Byte offsets are word aligned
package prs_pkg;
	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [11:0] PRS_OFF_CTRL = 12'h000;
	localparam logic [11:0] PRS_OFF_STATUS = 12'h004;
	localparam logic [11:0] PRS_OFF_EE_CMD = 12'h008;
	localparam logic [11:0] PRS_OFF_EE_DATA = 12'h00c;
	localparam logic [11:0] PRS_OFF_REFRESH = 12'h010;
	localparam logic [11:0] PRS_OFF_WDOG = 12'h014;
	localparam logic [11:0] PRS_OFF_WDOG_LIM = 12'h018;
	// ***************************************************************
	// Fields
	// ***************************************************************
	localparam int PRS_CTRL_COLD_BIT = 0;
	localparam int PRS_EE_CMD_GO_BIT = 31;
	localparam int PRS_EE_CMD_WR_BIT = 30;
	localparam int PRS_CFG_ENDIAN_BIT = 0;
	localparam int PRS_CFG_WIDE_BIT = 1;
	localparam int PRS_CFG_RSVD_BIT = 2;
	localparam int PRS_EE_ADDR_W = 8;
	localparam int PRS_CFG_BITS = 3;
	// ***************************************************************
	// Reset values and timing
	// ***************************************************************
	localparam logic [15:0] PRS_REFRESH_RST = 16'h1838;
	// Rollovers in about one minute at the default 62 us refresh period
	localparam logic [31:0] PRS_WDOG_LIM_RST = 32'h000e_c3a2;
	localparam int PRS_CLK_MHZ = 100;
	localparam int PRS_PLL_LOCK_MS = 100;
	localparam int PRS_CLK_STABLE_MS = 20;
	localparam int PRS_PLL2_LOCK_MS = 20;
	localparam int PRS_PLL_LOCK_CYC = PRS_PLL_LOCK_MS * 1000 * PRS_CLK_MHZ;
	localparam int PRS_CLK_STABLE_CYC = PRS_CLK_STABLE_MS * 1000 * PRS_CLK_MHZ;
	localparam int PRS_PLL2_LOCK_CYC = PRS_PLL2_LOCK_MS * 1000 * PRS_CLK_MHZ;
	localparam int PRS_EE_DIV = 50;
	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [3:0] {
		PRS_ST_HOLD, PRS_ST_CFG, PRS_ST_CFG_WAIT, PRS_ST_VCC, PRS_ST_COLD_REL,
		PRS_ST_CLK, PRS_ST_PLL, PRS_ST_DONE
	} prs_state_t;
	typedef struct packed {
		logic vccok;
		logic cold_rst_n;
		logic reset_n;
		logic pll_reset_out_n;
		logic own_pll_reset_n;
		logic chip_reset_n;
		logic exp_reset_n;
	} prs_resets_t;
	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} prs_ee_pins_t;
endpackage

// File: hdl/prs_ee_ctrl.sv
// Purpose: Bit-serial access engine for the config serial EEPROM
// Assumes: Microwire style pins, one bit per two divided clock ticks
// Notes: Reads or writes one bit at a given address per request
`timescale 1ns/1ps
module prs_ee_ctrl
	import prs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic wr,
	input wire logic [PRS_EE_ADDR_W-1:0] addr,
	input wire logic wdata,
	input wire logic ee_do,
	output prs_ee_pins_t pins,
	output logic busy,
	output logic done,
	output logic rdata
);
	// ***************************************************************
	// Bit clock divider
	// ***************************************************************
	logic [7:0] div_q;
	logic tick;
	assign tick = (div_q == 8'(PRS_EE_DIV - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else if (tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	// ***************************************************************
	// Shift sequence: start, opcode, address, data
	// ***************************************************************
	logic [11:0] frame_q;
	logic [4:0] cnt_q;
	logic sk_q;
	logic wr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt_q <= 5'h00;
			frame_q <= 12'h000;
			sk_q <= 1'b0;
			wr_q <= 1'b0;
			rdata <= 1'b0;
			pins <= '0;
		end else begin
			done <= 1'b0;
			if (!busy && req) begin
				busy <= 1'b1;
				wr_q <= wr;
				cnt_q <= 5'h00;
				sk_q <= 1'b0;
				frame_q <= {1'b1, wr ? 2'b01 : 2'b10, addr, wdata};
				pins <= '{cs: 1'b1, sk: 1'b0, di: 1'b1};
			end else if (busy && tick) begin
				sk_q <= !sk_q;
				pins.sk <= !sk_q;
				// Data moves only on the falling clock, so it is settled at each rise
				if (sk_q) begin
					frame_q <= {frame_q[10:0], 1'b0};
					pins.di <= frame_q[10];
					cnt_q <= cnt_q + 5'h01;
					// Last edge samples the returned data bit
					if (cnt_q == 5'd11) begin
						if (!wr_q) begin
							rdata <= ee_do;
						end
						busy <= 1'b0;
						done <= 1'b1;
						pins <= '0;
					end
				end
			end
		end
	end
endmodule

// File: hdl/prs_top.sv
// Purpose: Processor reset sequencer with EEPROM access and watchdog
// Assumes: pclk at 100 MHz, APB slave, synchronous inputs
// Notes: Long waits are parameters so a bench can shorten them
`timescale 1ns/1ps
module prs_top
	import prs_pkg::*;
#(
	parameter int PLL_LOCK_CYC = PRS_PLL_LOCK_CYC,
	parameter int CLK_STABLE_CYC = PRS_CLK_STABLE_CYC,
	parameter int PLL2_LOCK_CYC = PRS_PLL2_LOCK_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ee_do,
	output prs_ee_pins_t ee_pins,
	output prs_resets_t resets,
	output logic endian_big,
	output logic io_wide64
);
	// ***************************************************************
	// Bus decode
	// ***************************************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction
	logic wr_en;
	logic rd_en;
	logic mapped;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign mapped = hit(paddr, PRS_OFF_CTRL) || hit(paddr, PRS_OFF_STATUS) ||
		hit(paddr, PRS_OFF_EE_CMD) || hit(paddr, PRS_OFF_EE_DATA) ||
		hit(paddr, PRS_OFF_REFRESH) || hit(paddr, PRS_OFF_WDOG) ||
		hit(paddr, PRS_OFF_WDOG_LIM);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	// ***************************************************************
	// Registers
	// ***************************************************************
	logic [15:0] refresh_pre_q;
	logic [31:0] wdog_lim_q;
	logic [PRS_EE_ADDR_W-1:0] ee_addr_q;
	logic ee_wdata_q;
	logic ee_wr_q;
	logic ee_sw_req_q;
	logic cold_req_q;
	logic wdog_kick;
	assign wdog_kick = wr_en && hit(paddr, PRS_OFF_WDOG);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_pre_q <= PRS_REFRESH_RST;
			wdog_lim_q <= PRS_WDOG_LIM_RST;
			ee_addr_q <= '0;
			ee_wdata_q <= 1'b0;
			ee_wr_q <= 1'b0;
			ee_sw_req_q <= 1'b0;
			cold_req_q <= 1'b0;
		end else begin
			ee_sw_req_q <= 1'b0;
			cold_req_q <= 1'b0;
			if (wr_en && hit(paddr, PRS_OFF_REFRESH)) begin
				refresh_pre_q <= pwdata[15:0];
			end
			if (wr_en && hit(paddr, PRS_OFF_WDOG_LIM)) begin
				wdog_lim_q <= pwdata;
			end
			if (wr_en && hit(paddr, PRS_OFF_EE_CMD) && pwdata[PRS_EE_CMD_GO_BIT]) begin
				ee_addr_q <= pwdata[PRS_EE_ADDR_W-1:0];
				ee_wr_q <= pwdata[PRS_EE_CMD_WR_BIT];
				ee_wdata_q <= pwdata[PRS_EE_ADDR_W];
				ee_sw_req_q <= 1'b1;
			end
			if (wr_en && hit(paddr, PRS_OFF_CTRL) && pwdata[PRS_CTRL_COLD_BIT]) begin
				cold_req_q <= 1'b1;
			end
		end
	end
	// ***************************************************************
	// Refresh interval counter and watchdog
	// ***************************************************************
	logic [15:0] refresh_cnt_q;
	logic rollover;
	logic [31:0] wdog_cnt_q;
	logic wdog_fire;
	assign rollover = (refresh_cnt_q == 16'h0000);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_cnt_q <= PRS_REFRESH_RST;
		end else if (rollover) begin
			refresh_cnt_q <= refresh_pre_q;
		end else begin
			refresh_cnt_q <= refresh_cnt_q - 16'h0001;
		end
	end
	// Timeout scales with the preload, about a minute at the default
	assign wdog_fire = (wdog_cnt_q >= wdog_lim_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_cnt_q <= 32'h0000_0000;
		end else if (wdog_kick || wdog_fire) begin
			wdog_cnt_q <= 32'h0000_0000;
		end else if (rollover) begin
			wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
		end
	end
	// ***************************************************************
	// Sequencer
	// ***************************************************************
	prs_state_t st_q;
	logic [31:0] wait_q;
	logic [1:0] cfg_idx_q;
	logic [PRS_CFG_BITS-1:0] cfg_q;
	logic seq_req;
	logic ee_busy;
	logic ee_done;
	logic ee_rdata;
	logic restart;
	logic owner_seq_q;
	assign restart = cold_req_q || wdog_fire;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= PRS_ST_HOLD;
			wait_q <= 32'h0000_0000;
			cfg_idx_q <= 2'b00;
			cfg_q <= '0;
			resets <= '{vccok: 1'b0, default: 1'b0};
		end else if (restart) begin
			st_q <= PRS_ST_HOLD;
			wait_q <= 32'h0000_0000;
			resets <= '{vccok: 1'b0, default: 1'b0};
		end else begin
			case (st_q)
				PRS_ST_HOLD: begin
					cfg_idx_q <= 2'b00;
					if (!ee_busy) begin
						st_q <= PRS_ST_CFG;
					end
				end
				PRS_ST_CFG: begin
					st_q <= PRS_ST_CFG_WAIT;
				end
				PRS_ST_CFG_WAIT: begin
					if (ee_done) begin
						cfg_q[cfg_idx_q] <= ee_rdata;
						if (cfg_idx_q == 2'(PRS_CFG_BITS - 1)) begin
							st_q <= PRS_ST_VCC;
						end else begin
							cfg_idx_q <= cfg_idx_q + 2'b01;
							st_q <= PRS_ST_CFG;
						end
					end
				end
				PRS_ST_VCC: begin
					resets.vccok <= 1'b1;
					wait_q <= 32'h0000_0000;
					st_q <= PRS_ST_COLD_REL;
				end
				PRS_ST_COLD_REL: begin
					wait_q <= wait_q + 32'h0000_0001;
					if (wait_q == 32'(PLL_LOCK_CYC - 1)) begin
						resets.cold_rst_n <= 1'b1;
						wait_q <= 32'h0000_0000;
						st_q <= PRS_ST_CLK;
					end
				end
				PRS_ST_CLK: begin
					wait_q <= wait_q + 32'h0000_0001;
					if (wait_q == 32'(CLK_STABLE_CYC - 1)) begin
						resets.pll_reset_out_n <= 1'b1;
						resets.own_pll_reset_n <= 1'b1;
						wait_q <= 32'h0000_0000;
						st_q <= PRS_ST_PLL;
					end
				end
				PRS_ST_PLL: begin
					wait_q <= wait_q + 32'h0000_0001;
					if (wait_q == 32'(PLL2_LOCK_CYC - 1)) begin
						resets.chip_reset_n <= 1'b1;
						resets.exp_reset_n <= 1'b1;
						st_q <= PRS_ST_DONE;
					end
				end
				PRS_ST_DONE: begin
					resets.reset_n <= 1'b1;
				end
				default: begin
					st_q <= PRS_ST_HOLD;
				end
			endcase
		end
	end
	assign seq_req = (st_q == PRS_ST_CFG);
	// Software access is only granted outside the config read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owner_seq_q <= 1'b0;
		end else if (seq_req) begin
			owner_seq_q <= 1'b1;
		end else if (ee_done) begin
			owner_seq_q <= 1'b0;
		end
	end
	// ***************************************************************
	// Configuration outputs
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			endian_big <= 1'b0;
			io_wide64 <= 1'b0;
		end else begin
			endian_big <= cfg_q[PRS_CFG_ENDIAN_BIT];
			io_wide64 <= cfg_q[PRS_CFG_WIDE_BIT];
		end
	end
	// ***************************************************************
	// EEPROM engine
	// ***************************************************************
	logic ee_go;
	logic sw_pend_q;
	logic sw_rdata_q;
	logic sw_busy;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_pend_q <= 1'b0;
			sw_rdata_q <= 1'b0;
		end else begin
			if (ee_done && !owner_seq_q) begin
				sw_rdata_q <= ee_rdata;
			end
			if (ee_sw_req_q) begin
				sw_pend_q <= 1'b1;
			end else if (ee_go && !seq_req) begin
				sw_pend_q <= 1'b0;
			end
		end
	end
	assign ee_go = seq_req || (sw_pend_q && !ee_busy && st_q != PRS_ST_CFG_WAIT && st_q != PRS_ST_HOLD);
	assign sw_busy = sw_pend_q || ((ee_busy || ee_done) && !owner_seq_q);
	prs_ee_ctrl u_ee (
		.pclk(pclk),
		.presetn(presetn),
		.req(ee_go),
		.wr(seq_req ? 1'b0 : ee_wr_q),
		.addr(seq_req ? PRS_EE_ADDR_W'(cfg_idx_q) : ee_addr_q),
		.wdata(ee_wdata_q),
		.ee_do(ee_do),
		.pins(ee_pins),
		.busy(ee_busy),
		.done(ee_done),
		.rdata(ee_rdata)
	);
	// ***************************************************************
	// Read data
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, PRS_OFF_STATUS)) begin
				prdata <= {19'h00000, cfg_q[1:0], st_q, resets};
			end else if (hit(paddr, PRS_OFF_EE_DATA)) begin
				prdata <= {30'h0000_0000, sw_busy, sw_rdata_q};
			end else if (hit(paddr, PRS_OFF_REFRESH)) begin
				prdata <= {16'h0000, refresh_pre_q};
			end else if (hit(paddr, PRS_OFF_WDOG)) begin
				prdata <= wdog_cnt_q;
			end else if (hit(paddr, PRS_OFF_WDOG_LIM)) begin
				prdata <= wdog_lim_q;
			end
		end
	end
	// ***************************************************************
	// Checks
	// ***************************************************************
	a_cold_after_vcc: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(resets.cold_rst_n) |-> resets.vccok) else $error("cold release before vccok");
	a_warm_last: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(resets.reset_n) |-> resets.chip_reset_n && resets.exp_reset_n)
		else $error("warm reset released early");
	a_restart_holds: assert property (@(posedge pclk) disable iff (!presetn)
		restart |=> !resets.vccok && !resets.cold_rst_n && !resets.reset_n)
		else $error("restart did not assert resets");
	a_refresh_reload: assert property (@(posedge pclk) disable iff (!presetn)
		rollover |=> refresh_cnt_q == $past(refresh_pre_q)) else $error("preload missed");
	a_wdog_kick: assert property (@(posedge pclk) disable iff (!presetn)
		wdog_kick |=> wdog_cnt_q == 32'h0) else $error("kick did not clear");
	a_wdog_step: assert property (@(posedge pclk) disable iff (!presetn)
		rollover && !wdog_kick && !wdog_fire |=> wdog_cnt_q == $past(wdog_cnt_q) + 32'h1)
		else $error("watchdog step missing");
	a_endian_follow: assert property (@(posedge pclk) disable iff (!presetn)
		##2 endian_big == $past(cfg_q[PRS_CFG_ENDIAN_BIT])) else $error("endian wrong");
	a_vcc_after_cfg: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(resets.vccok) |-> $past(st_q) == PRS_ST_VCC) else $error("vccok early");
	a_pll_pair: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(resets.pll_reset_out_n) |-> resets.own_pll_reset_n && resets.cold_rst_n)
		else $error("pll resets split");
endmodule

// File: dv/prs_ee_model.sv
// Purpose: Behavioural serial EEPROM seen by the sequencer
// Assumes: Frame is start, two opcode bits, 8 address bits, one data bit
// Notes: Released data line shows the inverse of the last bit read
`timescale 1ns/1ps
module prs_ee_model
	import prs_pkg::*;
(
	input prs_ee_pins_t pins,
	output logic ee_do
);
	// ***********************************
	// Storage and frame decode
	// ***********************************
	logic mem [0:255];
	logic [10:0] hdr;
	logic last;
	int nbits;
	int rd_q[$];
	initial begin
		ee_do = 1'b0;
		last = 1'b0;
		nbits = 0;
	end
	always @(posedge pins.cs) nbits = 0;
	// Undriven line must not look like valid data
	always @(negedge pins.cs) ee_do = ~last;
	always @(posedge pins.sk) begin
		if (pins.cs) begin
			if (nbits < 11) begin
				hdr = {hdr[9:0], pins.di};
			end else if (nbits == 11 && hdr[10:8] == 3'b101) begin
				mem[hdr[7:0]] = pins.di;
			end
			nbits++;
			if (nbits == 11 && hdr[10:8] == 3'b110) begin
				ee_do = mem[hdr[7:0]];
				last = ee_do;
				rd_q.push_back(hdr[7:0]);
			end
		end
	end
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the processor reset sequencer
// Assumes: Shortened waits of 20, 10 and 10 cycles
// Notes: Expected values come from the EEPROM model and the rules
`timescale 1ns/1ps
module testbench;
	import prs_pkg::*;
	localparam int P1 = 20;
	localparam int P2 = 10;
	localparam int P3 = 10;
	localparam logic [7:0] DUP_ADDR = 8'h40;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ee_do;
	logic endian_big, io_wide64, e, b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] a;
	prs_ee_pins_t ee_pins;
	prs_resets_t resets;
	int err_count, checks, cyc, n, seed;
	prs_top #(.PLL_LOCK_CYC(P1), .CLK_STABLE_CYC(P2), .PLL2_LOCK_CYC(P3)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ee_do(ee_do), .ee_pins(ee_pins),
		.resets(resets), .endian_big(endian_big), .io_wide64(io_wide64));
	prs_ee_model ee (.pins(ee_pins), .ee_do(ee_do));
	// ***********************************
	// Tasks
	// ***********************************
	task automatic results;
		if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic ee_op(input logic w, input logic [7:0] ad, input logic d);
		apb(1'b1, PRS_OFF_EE_CMD, {1'b1, w, 21'h0, d, ad});
		r = 32'h0;
		while (r[1] !== 1'b1) apb(1'b0, PRS_OFF_EE_DATA, 32'h0);
		while (r[1] !== 1'b0) apb(1'b0, PRS_OFF_EE_DATA, 32'h0);
	endtask
	task automatic seq_check;
		while (resets.vccok !== 1'b1) @(posedge pclk);
		chk(ee.rd_q.size(), 3);
		for (int i = 0; i < 3; i++) chk(ee.rd_q[i], i);
		ee.rd_q.delete();
		n = 0;
		while (resets.cold_rst_n !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk(n >= P1 && n <= P1 + 3, 1);
		chk(endian_big, ee.mem[0]);
		chk(io_wide64, ee.mem[1]);
		n = 0;
		while (resets.pll_reset_out_n !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk(resets.own_pll_reset_n, 1);
		chk(n >= P2 && n <= P2 + 3, 1);
		n = 0;
		while (resets.chip_reset_n !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk({resets.exp_reset_n, resets.reset_n}, 2'b10);
		chk(n >= P3 && n <= P3 + 3, 1);
		repeat (2) @(posedge pclk);
		chk(resets.reset_n, 1);
	endtask
	// ***********************************
	// Clock, timeout and main sequence
	// ***********************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Ceiling sized for three sequences, the refresh drain and a few EEPROM accesses
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			results();
		end
	end
	initial begin
		seed = 32'h781d6eb5;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		checks = 0;
		cyc = 0;
		for (int i = 0; i < 256; i++) ee.mem[i] = $random(seed);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({25'h0, resets}, 32'h0);
		apb(1'b0, PRS_OFF_REFRESH, 32'h0);
		chk(r, {16'h0, PRS_REFRESH_RST});
		apb(1'b0, PRS_OFF_WDOG_LIM, 32'h0);
		chk(r, PRS_WDOG_LIM_RST);
		apb(1'b1, 12'h01c, 32'h5);
		chk(e, 1);
		apb(1'b0, 12'h01c, 32'h0);
		chk({e, r}, {1'b1, 32'h0});
		seq_check();
		a = {2'b10, 6'($random(seed))};
		b = $random(seed);
		ee_op(1'b1, a, b);
		chk(ee.mem[a], b);
		ee_op(1'b0, a, 1'b0);
		chk(r[0], b);
		b = ~ee.mem[0];
		ee_op(1'b1, 8'h00, b);
		ee_op(1'b1, DUP_ADDR, b);
		chk(ee.mem[DUP_ADDR], b);
		ee.rd_q.delete();
		apb(1'b1, PRS_OFF_CTRL, 32'h1);
		while (resets.vccok !== 1'b0) @(posedge pclk);
		chk(resets.cold_rst_n, 0);
		seq_check();
		chk(endian_big, b);
		// Let the long default preload run out before the short limit goes in
		apb(1'b1, PRS_OFF_REFRESH, 32'h3);
		repeat (6300) @(posedge pclk);
		apb(1'b1, PRS_OFF_WDOG, 32'h0);
		apb(1'b1, PRS_OFF_WDOG_LIM, 32'h4);
		apb(1'b1, PRS_OFF_WDOG, 32'h0);
		apb(1'b0, PRS_OFF_WDOG, 32'h0);
		chk(r <= 32'h1, 1);
		n = 0;
		while (resets.vccok !== 1'b0) begin
			@(posedge pclk);
			n++;
		end
		chk(n >= 8 && n <= 24, 1);
		chk({25'h0, resets}, 32'h0);
		apb(1'b1, PRS_OFF_WDOG_LIM, PRS_WDOG_LIM_RST);
		seq_check();
		results();
	end
endmodule
